// file: common/scg_pkg.sv
package scg_pkg;
    typedef logic [3:0]  scg_irq_t;
    typedef logic [31:0] scg_word_t;
    typedef enum logic [1:0] {
        SCG_RUN,
        SCG_SLEEP,
        SCG_DEEP
    } scg_power_mode_t;
endpackage : scg_pkg

// file: common/scg_regs.svh
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH

// register byte offsets
`define SCG_OFF_RIS        8'h00
`define SCG_OFF_MIS        8'h04
`define SCG_OFF_IMC        8'h08
`define SCG_OFF_ICLR       8'h0C
`define SCG_OFF_IEN_SET    8'h10
`define SCG_OFF_IEN_CLR    8'h14
`define SCG_OFF_GPIO_HS    8'h18
`define SCG_OFF_LDO        8'h1C
`define SCG_OFF_GATE_CTL   8'h20
`define SCG_OFF_SLP_EN     8'h24
`define SCG_OFF_DSLP_EN    8'h28
`define SCG_OFF_STATUS_VIEW 8'h2C

// interrupt bit positions
`define SCG_BIT_MOSC       0
`define SCG_BIT_USBPLL     1
`define SCG_BIT_PLL        2
`define SCG_BIT_BOR        3

// gpio port bit positions in the fast-bus select field
`define SCG_PORT_A         0
`define SCG_PORT_B         1
`define SCG_PORT_C         2
`define SCG_PORT_E         4
`define SCG_PORT_F         5
`define SCG_PORT_H         7
`define SCG_GPIO_HS_VALID  8'hB7

// reset values and the regulator code limit
`define SCG_LDO_RESET      4'h0
`define SCG_LDO_MAX        4'hA
`define SCG_PERIPH_RESET   32'hFFFFFFFF

`endif

// file: rtl/scg_clock_gate.sv
`timescale 1ns/100ps
// clock-run decision for one peripheral
module scg_clock_gate
    import scg_pkg::*;
(
    input  wire logic            i_gating_on,
    input  wire scg_power_mode_t i_mode,
    input  wire logic            i_run_en,
    input  wire logic            i_sleep_en,
    input  wire logic            i_deep_en,
    output logic                 o_clk_run
);
    wire sleep_run = i_gating_on ? i_sleep_en : i_run_en;
    wire deep_run  = i_gating_on ? i_deep_en  : i_run_en;
    assign o_clk_run = (i_mode == SCG_SLEEP) ? sleep_run :
                       (i_mode == SCG_DEEP)  ? deep_run  : i_run_en;
endmodule : scg_clock_gate

// file: rtl/scg_irq_bit.sv
`timescale 1ns/100ps
// one sticky interrupt flag with its enable bit
module scg_irq_bit
(
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_event,
    input  wire logic i_clear,
    input  wire logic i_enable_set,
    input  wire logic i_enable_clr,
    output logic      o_raw,
    output logic      o_enable
);
    // set wins over clear
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_raw <= 1'b0;
        else if (i_event)
            o_raw <= 1'b1;
        else if (i_clear)
            o_raw <= 1'b0;
    end

    // enable changes only on its own request
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_enable <= 1'b0;
        else if (i_enable_set)
            o_enable <= 1'b1;
        else if (i_enable_clr)
            o_enable <= 1'b0;
    end
endmodule : scg_irq_bit

// file: rtl/scg_sysctrl.sv
`timescale 1ns/100ps
`include "scg_regs.svh"
// Function
// - a gpio port with fast access off is served on the peripheral bus.
// - a gpio port with fast access on is served on the fast bus window.
// - bus selection exists only for ports a, b, c, e, f and h.
// - four separately flagged interrupt sources share one bit layout.
// - writing a clear mask clears selected pending flags and no others.
// - each source enable can be set or cleared without touching the rest.
// - only enabled pending sources drive the processor interrupt.
// - raw and masked status are both readable.
// - the regulator field is read and write, resets to 2.5 V, 2.25 to 2.75 V.
// - with gating off every peripheral is clocked in sleep as in run.
// - with gating on sleep clocks follow per-peripheral sleep bits.
// - deep-sleep bits are kept while gating is off but have no effect.
// - a stopped peripheral keeps state and resumes on return to run.
module scg_sysctrl
    import scg_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_reset_n,
    input  wire logic [7:0]      i_addr,
    input  wire logic [31:0]     i_wdata,
    input  wire logic            i_write,
    input  wire logic            i_read,
    output logic      [31:0]     o_rdata,
    input  wire logic            i_main_osc_powerup_irq,
    input  wire logic            i_usb_pll_locked_irq,
    input  wire logic            i_pll_locked_irq,
    input  wire logic            i_brownout_irq,
    output logic                 o_irq,
    input  wire scg_power_mode_t i_power_mode,
    input  wire logic [31:0]     i_periph_run_en,
    output logic      [31:0]     o_periph_clk_run,
    output logic      [7:0]      o_gpio_fast_sel,
    input  wire logic [7:0]      i_gpio_access,
    output logic      [7:0]      o_gpio_fast_access,
    output logic      [7:0]      o_gpio_slow_access,
    output logic      [3:0]      o_ldo_setting
);
    // address decode
    wire sel_ris    = (i_addr == `SCG_OFF_RIS);
    wire sel_mis    = (i_addr == `SCG_OFF_MIS);
    wire sel_imc    = (i_addr == `SCG_OFF_IMC);
    wire sel_iclr   = (i_addr == `SCG_OFF_ICLR);
    wire sel_ien_s  = (i_addr == `SCG_OFF_IEN_SET);
    wire sel_ien_c  = (i_addr == `SCG_OFF_IEN_CLR);
    wire sel_gpio   = (i_addr == `SCG_OFF_GPIO_HS);
    wire sel_ldo    = (i_addr == `SCG_OFF_LDO);
    wire sel_gate   = (i_addr == `SCG_OFF_GATE_CTL);
    wire sel_slp    = (i_addr == `SCG_OFF_SLP_EN);
    wire sel_dslp   = (i_addr == `SCG_OFF_DSLP_EN);
    wire sel_view   = (i_addr == `SCG_OFF_STATUS_VIEW);

    scg_irq_t irq_event;
    scg_irq_t irq_raw;
    scg_irq_t irq_en;
    scg_irq_t irq_masked;
    scg_irq_t clr_mask;
    scg_irq_t en_set_mask;
    scg_irq_t en_clr_mask;
    logic     prev_mosc;
    logic     prev_usb;
    logic     prev_pll;
    logic     prev_bor;

    // rising edges of the source levels are the events
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            prev_mosc <= 1'b0;
            prev_usb  <= 1'b0;
            prev_pll  <= 1'b0;
            prev_bor  <= 1'b0;
        end
        else
        begin
            prev_mosc <= i_main_osc_powerup_irq;
            prev_usb  <= i_usb_pll_locked_irq;
            prev_pll  <= i_pll_locked_irq;
            prev_bor  <= i_brownout_irq;
        end
    end

    // four sources, one bit each in a shared layout
    assign irq_event[`SCG_BIT_MOSC]   = i_main_osc_powerup_irq & ~prev_mosc;
    assign irq_event[`SCG_BIT_USBPLL] = i_usb_pll_locked_irq & ~prev_usb;
    assign irq_event[`SCG_BIT_PLL]    = i_pll_locked_irq & ~prev_pll;
    assign irq_event[`SCG_BIT_BOR]    = i_brownout_irq & ~prev_bor;

    // write-one masks for clear and enable set/clear
    wire clr_write     = i_write && (sel_iclr || sel_ris || sel_mis);
    assign clr_mask    = clr_write ? i_wdata[3:0] : 4'h0;
    assign en_set_mask = (i_write && sel_ien_s) ? i_wdata[3:0] : 4'h0;
    assign en_clr_mask = (i_write && sel_ien_c) ? i_wdata[3:0] : 4'h0;
    wire imc_write     = i_write && sel_imc;

    // sticky flags and enables
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_irq
            scg_irq_bit u_bit
            (
                .i_clk        (i_clk),
                .i_reset_n    (i_reset_n),
                .i_event      (irq_event[g]),
                .i_clear      (clr_mask[g]),
                .i_enable_set (en_set_mask[g] | (imc_write & i_wdata[g])),
                .i_enable_clr (en_clr_mask[g] | (imc_write & ~i_wdata[g])),
                .o_raw        (irq_raw[g]),
                .o_enable     (irq_en[g])
            );
        end
    endgenerate

    // masked view and interrupt output
    assign irq_masked = irq_raw & irq_en;
    assign o_irq      = |irq_masked;

    // fast-bus selection, only defined ports may be set
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_gpio_fast_sel <= 8'h00;
        else if (i_write && sel_gpio)
            o_gpio_fast_sel <= i_wdata[7:0] & `SCG_GPIO_HS_VALID;
    end

    // route each port's access to one bus window
    assign o_gpio_fast_access = i_gpio_access & o_gpio_fast_sel;
    assign o_gpio_slow_access = i_gpio_access & ~o_gpio_fast_sel;

    // regulator setting, out-of-range codes ignored
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_ldo_setting <= `SCG_LDO_RESET;
        else if (i_write && sel_ldo && (i_wdata[3:0] <= `SCG_LDO_MAX))
            o_ldo_setting <= i_wdata[3:0];
    end

    // gating control and per-peripheral sleep configuration
    logic        gating_on;
    logic [31:0] sleep_en;
    logic [31:0] deep_en;
    logic        view_masked;
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            gating_on   <= 1'b0;
            sleep_en    <= `SCG_PERIPH_RESET;
            deep_en     <= `SCG_PERIPH_RESET;
            view_masked <= 1'b0;
        end
        else
        begin
            if (i_write && sel_gate)
                gating_on <= i_wdata[0];
            if (i_write && sel_slp)
                sleep_en <= i_wdata;
            if (i_write && sel_dslp)
                deep_en <= i_wdata;
            if (i_write && sel_view)
                view_masked <= i_wdata[0];
        end
    end

    // per-peripheral clock decisions; gated clocks keep state in the peripheral
    generate
        for (g = 0; g < 32; g++)
        begin : g_gate
            scg_clock_gate u_gate
            (
                .i_gating_on (gating_on),
                .i_mode      (i_power_mode),
                .i_run_en    (i_periph_run_en[g]),
                .i_sleep_en  (sleep_en[g]),
                .i_deep_en   (deep_en[g]),
                .o_clk_run   (o_periph_clk_run[g])
            );
        end
    endgenerate

    // read mux
    scg_word_t rd_mux;
    wire [3:0] view_sel = view_masked ? irq_masked : irq_raw;
    assign rd_mux = sel_ris  ? {28'h0000000, irq_raw} :
                    sel_mis  ? {28'h0000000, irq_masked} :
                    sel_imc  ? {28'h0000000, irq_en} :
                    sel_ien_s ? {28'h0000000, irq_en} :
                    sel_gpio ? {24'h000000, o_gpio_fast_sel} :
                    sel_ldo  ? {28'h0000000, o_ldo_setting} :
                    sel_gate ? {31'h00000000, gating_on} :
                    sel_slp  ? sleep_en :
                    sel_dslp ? deep_en :
                    sel_view ? {27'h0000000, view_sel, view_masked} :
                    32'h00000000;

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_rdata <= 32'h00000000;
        else if (i_read)
            o_rdata <= rd_mux;
        else
            o_rdata <= 32'h00000000;
    end
endmodule : scg_sysctrl

// file: sim/scg_irq_sink.sv
`timescale 1ns/100ps
// processor interrupt input: counts handler entries
module scg_irq_sink
(
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_irq,
    output int        o_entries
);
    logic prev_irq;
    // an entry only when the line rises
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            prev_irq  <= 1'b0;
            o_entries <= 0;
        end
        else
        begin
            prev_irq <= i_irq;
            if (i_irq && !prev_irq)
                o_entries <= o_entries + 1;
        end
    end
endmodule : scg_irq_sink

// file: sim/scg_sysctrl_chk.sv
`timescale 1ns/100ps
// port-level checks of the system control block
module scg_sysctrl_chk
    import scg_pkg::*;
(
    input wire logic            i_clk,
    input wire logic            i_reset_n,
    input wire logic [7:0]      i_addr,
    input wire logic [31:0]     i_wdata,
    input wire logic            i_write,
    input wire logic            i_read,
    input wire logic [31:0]     o_rdata,
    input wire logic            i_main_osc_powerup_irq,
    input wire logic            i_usb_pll_locked_irq,
    input wire logic            i_pll_locked_irq,
    input wire logic            i_brownout_irq,
    input wire logic            o_irq,
    input wire scg_power_mode_t i_power_mode,
    input wire logic [31:0]     i_periph_run_en,
    input wire logic [31:0]     o_periph_clk_run,
    input wire logic [7:0]      o_gpio_fast_sel,
    input wire logic [7:0]      i_gpio_access,
    input wire logic [7:0]      o_gpio_fast_access,
    input wire logic [7:0]      o_gpio_slow_access,
    input wire logic [3:0]      o_ldo_setting
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // clear of every flag while all sources are quiet
    sequence clr_all;
        i_write && i_addr == 8'h0C && i_wdata[3:0] == 4'hF && !(i_main_osc_powerup_irq
            || i_usb_pll_locked_irq || i_pll_locked_irq || i_brownout_irq);
    endsequence
    sequence ldo_ok_wr;
        i_write && i_addr == 8'h1C && i_wdata[3:0] <= 4'hA;
    endsequence
    rdata_idle_a: assert property (!$past(i_read) |-> o_rdata == 32'h0)
        else $error("read data outside read slot");
    ldo_load_a: assert property (ldo_ok_wr |=> o_ldo_setting == $past(i_wdata[3:0]))
        else $error("regulator code not loaded");
    ldo_keep_a: assert property (
        !(i_write && i_addr == 8'h1C && i_wdata[3:0] <= 4'hA) |=> $stable(o_ldo_setting))
        else $error("regulator code moved");
    fast_route_a: assert property (
        o_gpio_fast_access == (i_gpio_access & o_gpio_fast_sel))
        else $error("fast route wrong");
    slow_route_a: assert property (
        o_gpio_slow_access == (i_gpio_access & ~o_gpio_fast_sel))
        else $error("slow route wrong");
    port_set_a: assert property (!o_gpio_fast_sel[3] && !o_gpio_fast_sel[6])
        else $error("select on missing port");
    run_clock_a: assert property (i_power_mode == SCG_RUN |->
        o_periph_clk_run == i_periph_run_en) else $error("run clock wrong");
    clear_all_a: assert property (clr_all |=> !o_irq)
        else $error("irq after clear");
    mask_off_a: assert property (i_write && i_addr == 8'h08 && i_wdata[3:0] == 4'h0
        |=> !o_irq) else $error("irq while masked");
endmodule : scg_sysctrl_chk

bind scg_sysctrl scg_sysctrl_chk u_scg_sysctrl_chk (.i_clk, .i_reset_n, .i_addr, .i_wdata,
    .i_write, .i_read, .o_rdata, .i_main_osc_powerup_irq, .i_usb_pll_locked_irq,
    .i_pll_locked_irq, .i_brownout_irq, .o_irq, .i_power_mode, .i_periph_run_en,
    .o_periph_clk_run, .o_gpio_fast_sel, .i_gpio_access, .o_gpio_fast_access,
    .o_gpio_slow_access, .o_ldo_setting);

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench
    import scg_pkg::*;
;
    logic            i_clk, i_reset_n, i_write, i_read, o_irq;
    logic [7:0]      i_addr, i_gpio_access, o_gpio_fast_sel;
    logic [7:0]      o_gpio_fast_access, o_gpio_slow_access;
    logic [31:0]     i_wdata, i_periph_run_en, o_rdata, o_periph_clk_run, d, s, p, m;
    logic [3:0]      src, o_ldo_setting, raw, en, l;
    scg_power_mode_t i_power_mode;
    int              num_errors, checks_done, cycles, entries;
    scg_sysctrl u_scg_sysctrl (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_write, .i_read,
        .o_rdata, .i_main_osc_powerup_irq(src[0]), .i_usb_pll_locked_irq(src[1]),
        .i_pll_locked_irq(src[2]), .i_brownout_irq(src[3]), .o_irq, .i_power_mode,
        .i_periph_run_en, .o_periph_clk_run, .o_gpio_fast_sel, .i_gpio_access,
        .o_gpio_fast_access, .o_gpio_slow_access, .o_ldo_setting);
    scg_irq_sink u_scg_irq_sink (.i_clk, .i_reset_n, .i_irq(o_irq), .o_entries(entries));
    // clock and hang guard
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    // bus cycles: strobe one cycle, then look just after the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        {i_addr, i_wdata, i_write} <= {a, v, 1'b1};
        @(posedge i_clk);
        i_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        {i_addr, i_read} <= {a, 1'b1};
        @(posedge i_clk);
        i_read <= 1'b0;
        #1 v = o_rdata;
    endtask : rd
    task automatic pulse(input int k);
        @(posedge i_clk);
        src[k] <= 1'b1;
        @(posedge i_clk);
        src[k] <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask : pulse
    function automatic logic [31:0] exp_clk(input logic g, input scg_power_mode_t md,
        input logic [31:0] r, input logic [31:0] sl, input logic [31:0] dp);
        if (!g || md == SCG_RUN)
            return r;
        return (md == SCG_SLEEP) ? sl : dp;
    endfunction : exp_clk
    initial
    begin
        {i_reset_n, i_write, i_read, i_addr, i_wdata, src, raw} = '0;
        {i_periph_run_en, i_gpio_access} = '0;
        i_power_mode = SCG_RUN;
        void'($urandom(8236));
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(8'h1C, d);
        chk("ldo", 32'h0, d);
        rd(8'h28, d);
        chk("deep_en", 32'hFFFFFFFF, d);
        rd(8'h40, d);
        chk("unmapped", 32'h0, d);
        // every regulator code, then two out of range
        for (int c = 0; c < 13; c++)
        begin
            wr(8'h1C, 32'(c));
            if (c <= 10) l = 4'(c);
            chk("ldo", l, o_ldo_setting);
        end
        // mid-run reset puts the regulator code back
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        chk("ldo_rst", 32'h0, o_ldo_setting);
        // port selection and access routing
        repeat (4)
        begin
            s = $urandom;
            wr(8'h18, s);
            @(posedge i_clk);
            i_gpio_access <= 8'($urandom);
            @(posedge i_clk);
            #1 m = s & 32'hB7;
            chk("sel", m, o_gpio_fast_sel);
            chk("fast", 8'(i_gpio_access & m[7:0]), o_gpio_fast_access);
            chk("slow", 8'(i_gpio_access & ~m[7:0]), o_gpio_slow_access);
        end
        // interrupt flags, enables, views and clears
        for (int r = 0; r < 3; r++)
        begin
            en = (r == 0) ? 4'hF : 4'($urandom);
            wr(8'h08, en);
            for (int k = 0; k < 4; k++)
            begin
                pulse(k);
                raw[k] = 1'b1;
                chk("irq", |(raw & en), o_irq);
            end
            rd(8'h00, d);
            chk("raw", raw, d);
            rd(8'h04, d);
            chk("masked", raw & en, d);
            wr(8'h2C, 32'h1);
            rd(8'h2C, d);
            chk("view", {27'h0, raw & en, 1'b1}, d);
            wr(8'h2C, 32'h0);
            rd(8'h2C, d);
            chk("view", {27'h0, raw, 1'b0}, d);
            m = $urandom;
            wr(8'h10, m);
            en |= m[3:0];
            m = $urandom;
            wr(8'h14, m);
            en &= ~m[3:0];
            rd(8'h08, d);
            chk("enable", en, d);
            m = (r == 2) ? 32'hF : $urandom;
            wr(8'h0C, m);
            raw &= ~m[3:0];
            rd(8'h04, d);
            chk("masked", raw & en, d);
            chk("irq", |(raw & en), o_irq);
        end
        // event in the same cycle as its clear: the set wins
        @(posedge i_clk);
        {i_addr, i_wdata, i_write} <= {8'h0C, 32'h1, 1'b1};
        src[0] <= 1'b1;
        @(posedge i_clk);
        {i_write, src[0]} <= 2'b00;
        rd(8'h00, d);
        chk("set_wins", 32'h1, d);
        wr(8'h0C, 32'h1);
        chk("entries", 1, entries > 0);
        // peripheral clocks with gating off then on
        s = $urandom;
        wr(8'h24, s);
        p = $urandom;
        wr(8'h28, p);
        for (int g = 0; g < 2; g++)
        begin
            wr(8'h20, 32'(g));
            for (int md = 0; md < 3; md++)
            begin
                @(posedge i_clk);
                i_power_mode <= scg_power_mode_t'(md);
                i_periph_run_en <= $urandom;
                @(posedge i_clk);
                #1 d = exp_clk(g[0], i_power_mode, i_periph_run_en, s, p);
                chk("clk_run", d, o_periph_clk_run);
            end
            rd(8'h28, d);
            chk("deep_keep", p, d);
        end
        wr(8'h08, 32'h0);
        chk("irq", 1'b0, o_irq);
        conclude();
    end
endmodule : testbench
